// >>> dsrrc_defines.svh
// Offsets, field positions, reset values and timing counts
`ifndef DSRRC_DEFINES_SVH
`define DSRRC_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DSRRC_OFF_MODE0      8'h00
`define DSRRC_OFF_MODE3      8'h04
`define DSRRC_OFF_LAT        8'h08
`define DSRRC_OFF_STATUS     8'h0c
`define DSRRC_OFF_CAL        8'h10
`define DSRRC_OFF_ROWBASE    8'h20

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DSRRC_BL_FIXED8      2'h0
`define DSRRC_BL_OTF         2'h1
`define DSRRC_BL_FIXED4      2'h2
`define DSRRC_M3_EN_BIT      2
`define DSRRC_CAL_RESET      8'haa
`define DSRRC_AL_RESET       4'h0
`define DSRRC_CL_RESET       4'h5
`define DSRRC_CHOP_BIT       12
`define DSRRC_AP_BIT         10
`define DSRRC_NIBBLE_BIT     2

// ----------------------------------------
// Timing
// ----------------------------------------
`define DSRRC_CLK_MHZ        20
`define DSRRC_TRP_NS         15
`define DSRRC_TRP_CYC        (((`DSRRC_TRP_NS * `DSRRC_CLK_MHZ) + 999) / 1000)
`define DSRRC_CCD_CYC        4
`define DSRRC_BEATS_FULL     4'h8
`define DSRRC_BEATS_CHOP     4'h4

`endif

// >>> dsrrc_pkg.sv
// Types shared by the row and read control files
package dsrrc_pkg;
    typedef enum logic [2:0] {
        DSRRC_CMD_NOP = 3'b000,
        DSRRC_CMD_ACT = 3'b001,
        DSRRC_CMD_PRE = 3'b010,
        DSRRC_CMD_RD  = 3'b011,
        DSRRC_CMD_WR  = 3'b100
    } dsrrc_cmd_t;
    typedef enum logic [1:0] {
        DSRRC_BK_IDLE = 2'b00,
        DSRRC_BK_OPEN = 2'b01,
        DSRRC_BK_PRE  = 2'b10
    } dsrrc_bank_t;
endpackage : dsrrc_pkg

// >>> dsrrc_bank.sv
// One bank's row state and precharge timer
`timescale 1ns/100ps
`include "dsrrc_defines.svh"
module dsrrc_bank (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       act_i,
    input  wire logic                       pre_i,
    input  wire logic [15:0]                row_i,
    output dsrrc_pkg::dsrrc_bank_t          state_o,
    output logic      [15:0]                row_o
);
    import dsrrc_pkg::*;

    dsrrc_bank_t state_q;
    logic [15:0] row_q;
    logic [3:0]  trp_q;

    // ----------------------------------------
    // Row state
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= DSRRC_BK_IDLE;
            row_q   <= 16'h0000;
            trp_q   <= 4'h0;
        end else if (pre_i) begin
            // Restarts even when idle or already closing
            state_q <= DSRRC_BK_PRE;
            trp_q   <= 4'(`DSRRC_TRP_CYC);
        end else if (act_i) begin
            state_q <= DSRRC_BK_OPEN;
            row_q   <= row_i;
        end else if (state_q == DSRRC_BK_PRE) begin
            if (trp_q <= 4'h1) begin
                state_q <= DSRRC_BK_IDLE;
                trp_q   <= 4'h0;
            end else begin
                trp_q   <= trp_q - 4'h1;
            end
        end
    end

    assign state_o = state_q;
    assign row_o   = row_q;
endmodule : dsrrc_bank

// >>> dsrrc_top.sv
// Row activate, precharge and read burst control of a DRAM device
`timescale 1ns/100ps
`include "dsrrc_defines.svh"
module dsrrc_top (
    input  wire logic                       CLK_I,
    input  wire logic                       SRST_I,
    // Wishbone slave
    input  wire logic                       CYC_I,
    input  wire logic                       STB_I,
    input  wire logic                       WE_I,
    input  wire logic [7:0]                 ADR_I,
    input  wire logic [3:0]                 SEL_I,
    input  wire logic [31:0]                DAT_I,
    output logic      [31:0]                DAT_O,
    output logic                            ACK_O,
    // Command port, same clock as controller
    input  wire logic                       CMD_VALID_I,
    input  wire dsrrc_pkg::dsrrc_cmd_t      CMD_I,
    input  wire logic [2:0]                 BANK_I,
    input  wire logic [15:0]                ADDR_I,
    input  wire logic                       DLL_LOCKED_I,
    // Read data and command error flag
    output logic                            RD_VALID_O,
    output logic [7:0]                      RD_DATA_O,
    output logic                            CMD_ERR_O
);
    import dsrrc_pkg::*;

    localparam int NB = 8;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [1:0]  bl_mode_q;
    logic        cal_en_q;
    logic [1:0]  cal_loc_q;
    logic [3:0]  al_q;
    logic [3:0]  cl_q;
    logic [7:0]  cal_pat_q;
    logic        err_q;
    logic        ack_q;
    logic [31:0] dat_q;

    // ----------------------------------------
    // Banks
    // ----------------------------------------
    dsrrc_bank_t bk_state [NB];
    logic [15:0] bk_row   [NB];
    logic [NB-1:0] act_sel;
    logic [NB-1:0] pre_sel;
    logic [NB-1:0] ap_sel_q;

    wire is_act   = CMD_VALID_I && (CMD_I == DSRRC_CMD_ACT);
    wire is_pre   = CMD_VALID_I && (CMD_I == DSRRC_CMD_PRE);
    wire is_rd    = CMD_VALID_I && (CMD_I == DSRRC_CMD_RD);
    wire is_wr    = CMD_VALID_I && (CMD_I == DSRRC_CMD_WR);
    wire pre_all  = ADDR_I[`DSRRC_AP_BIT];
    wire auto_pre = ADDR_I[`DSRRC_AP_BIT];
    wire bank_open = (bk_state[BANK_I] == DSRRC_BK_OPEN);
    // Column accesses need an open row unless served from the pattern
    wire col_ok   = bank_open || (is_rd && cal_en_q);

    genvar g;
    generate
        for (g = 0; g < NB; g++) begin : g_bank
            assign act_sel[g] = is_act && (BANK_I == 3'(g));
            assign pre_sel[g] = (is_pre && (pre_all || BANK_I == 3'(g)))
                                || ap_sel_q[g];
            dsrrc_bank u_bank (
                .clk_i   (CLK_I),
                .rst_i   (SRST_I),
                .act_i   (act_sel[g]),
                .pre_i   (pre_sel[g]),
                .row_i   (ADDR_I),
                .state_o (bk_state[g]),
                .row_o   (bk_row[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Burst length selection
    // ----------------------------------------
    // Bit twelve goes here and into the activated row, never into a column index
    wire chop_bit = ADDR_I[`DSRRC_CHOP_BIT];
    wire use_chop = (bl_mode_q == `DSRRC_BL_FIXED4) ||
                    ((bl_mode_q == `DSRRC_BL_OTF) && !chop_bit);
    wire [3:0] beats = use_chop ? `DSRRC_BEATS_CHOP : `DSRRC_BEATS_FULL;
    wire upper_nib   = use_chop && ADDR_I[`DSRRC_NIBBLE_BIT];
    wire [7:0] col_lo = ADDR_I[7:0];

    // ----------------------------------------
    // Read pipeline: delay line of issued reads
    // ----------------------------------------
    // Latency up to 30 cycles; fixed depth chosen to keep it flops only
    localparam int DL = 32;
    logic [DL-1:0] pend_q;
    logic [3:0]    pb_beats_q [DL];
    logic [DL-1:0] pb_cal_q;
    logic [DL-1:0] pb_up_q;
    logic [7:0]    pb_col_q [DL];
    wire  [4:0]    rl = 5'(al_q) + 5'(cl_q);
    wire           rd_go = is_rd && col_ok && DLL_LOCKED_I;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            pend_q   <= '0;
            pb_cal_q <= '0;
            pb_up_q  <= '0;
            for (int i = 0; i < DL; i++) begin
                pb_beats_q[i] <= 4'h0;
                pb_col_q[i]   <= 8'h00;
            end
        end else begin
            for (int i = 0; i < DL-1; i++) begin
                pend_q[i]     <= pend_q[i+1];
                pb_beats_q[i] <= pb_beats_q[i+1];
                pb_cal_q[i]   <= pb_cal_q[i+1];
                pb_up_q[i]    <= pb_up_q[i+1];
                pb_col_q[i]   <= pb_col_q[i+1];
            end
            pend_q[DL-1] <= 1'b0;
            if (rd_go) begin
                // Slot rl-1 reaches the head rl cycles after the command
                pend_q[rl - 5'h1]     <= 1'b1;
                pb_beats_q[rl - 5'h1] <= beats;
                pb_cal_q[rl - 5'h1]   <= cal_en_q;
                pb_up_q[rl - 5'h1]    <= upper_nib;
                pb_col_q[rl - 5'h1]   <= col_lo;
            end
        end
    end

    // ----------------------------------------
    // Burst output
    // ----------------------------------------
    logic [3:0] left_q;
    logic [2:0] idx_q;
    logic       cal_q;
    logic [7:0] col_q;
    logic       rv_q;
    logic [7:0] rdat_q;
    wire  [7:0] pat = (cal_loc_q == 2'h0) ? cal_pat_q : 8'h00;
    wire        start = pend_q[0];
    wire  [2:0] s_idx = pb_up_q[0] ? 3'h4 : 3'h0;
    wire  [2:0] b_idx = start ? s_idx : idx_q;
    wire        b_cal = start ? pb_cal_q[0] : cal_q;
    wire  [7:0] b_col = start ? pb_col_q[0] : col_q;
    wire        b_on  = start || (left_q != 4'h0);
    // Array contents are not modelled; beats carry the column index
    wire  [7:0] b_dat = b_cal ? {8{pat[b_idx]}} : (b_col + 8'(b_idx));

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            left_q <= 4'h0;
            idx_q  <= 3'h0;
            cal_q  <= 1'b0;
            col_q  <= 8'h00;
            rv_q   <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            rv_q   <= b_on;
            rdat_q <= b_on ? b_dat : 8'h00;
            if (start) begin
                left_q <= pb_beats_q[0] - 4'h1;
                idx_q  <= s_idx + 3'h1;
                cal_q  <= pb_cal_q[0];
                col_q  <= pb_col_q[0];
            end else if (left_q != 4'h0) begin
                left_q <= left_q - 4'h1;
                idx_q  <= idx_q + 3'h1;
            end
        end
    end

    // ----------------------------------------
    // Auto precharge after column access
    // ----------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ap_sel_q <= '0;
            err_q    <= 1'b0;
        end else begin
            // Other banks stay free for new column commands meanwhile
            for (int i = 0; i < NB; i++) begin
                ap_sel_q[i] <= (is_rd || is_wr) && bank_open && auto_pre
                               && (BANK_I == 3'(i));
            end
            if ((is_rd || is_wr) && !col_ok) begin
                err_q <= 1'b1;
            end else if (is_act && bank_open) begin
                err_q <= 1'b1;
            end else if (ack_q && WE_I && ADR_I == `DSRRC_OFF_STATUS) begin
                err_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Wishbone registers
    // ----------------------------------------
    wire        req    = CYC_I && STB_I && !ack_q;
    wire        wr_req = req && WE_I && SEL_I[0];
    wire [2:0]  rbank  = ADR_I[4:2];
    wire        in_row = (ADR_I[7:5] == 3'h1);
    wire [31:0] rd_mux =
        (ADR_I == `DSRRC_OFF_MODE0)  ? {30'h0, bl_mode_q} :
        (ADR_I == `DSRRC_OFF_MODE3)  ? {29'h0, cal_en_q, cal_loc_q} :
        (ADR_I == `DSRRC_OFF_LAT)    ? {24'h0, cl_q, al_q} :
        (ADR_I == `DSRRC_OFF_STATUS) ? {22'h0, bk_state[7] == DSRRC_BK_OPEN,
                                        bk_state[6] == DSRRC_BK_OPEN,
                                        bk_state[5] == DSRRC_BK_OPEN,
                                        bk_state[4] == DSRRC_BK_OPEN,
                                        bk_state[3] == DSRRC_BK_OPEN,
                                        bk_state[2] == DSRRC_BK_OPEN,
                                        bk_state[1] == DSRRC_BK_OPEN,
                                        bk_state[0] == DSRRC_BK_OPEN,
                                        DLL_LOCKED_I, err_q} :
        (ADR_I == `DSRRC_OFF_CAL)    ? {24'h0, cal_pat_q} :
        in_row                       ? {16'h0, bk_row[rbank]} : 32'h0;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            bl_mode_q <= `DSRRC_BL_FIXED8;
            cal_en_q  <= 1'b0;
            cal_loc_q <= 2'h0;
            al_q      <= `DSRRC_AL_RESET;
            cl_q      <= `DSRRC_CL_RESET;
            cal_pat_q <= `DSRRC_CAL_RESET;
            ack_q     <= 1'b0;
            dat_q     <= 32'h0;
        end else begin
            ack_q <= req;
            dat_q <= req ? rd_mux : 32'h0;
            if (wr_req) begin
                unique case (ADR_I)
                    `DSRRC_OFF_MODE0: bl_mode_q <= DAT_I[1:0];
                    `DSRRC_OFF_MODE3: begin
                        cal_en_q  <= DAT_I[`DSRRC_M3_EN_BIT];
                        cal_loc_q <= DAT_I[1:0];
                    end
                    `DSRRC_OFF_LAT: begin
                        al_q <= DAT_I[3:0];
                        cl_q <= (DAT_I[7:4] == 4'h0) ? 4'h1 : DAT_I[7:4];
                    end
                    `DSRRC_OFF_CAL: cal_pat_q <= DAT_I[7:0];
                    default: ;
                endcase
            end
        end
    end

    assign ACK_O      = ack_q;
    assign DAT_O      = dat_q;
    assign RD_VALID_O = rv_q;
    assign RD_DATA_O  = rdat_q;
    assign CMD_ERR_O  = err_q;
endmodule : dsrrc_top

// >>> dsrrc_ctl_model.sv
// Memory controller model driving the command port
`timescale 1ns/100ps
module dsrrc_ctl_model (
    input  wire logic             clk_i,
    output logic                  cmd_valid_o,
    output dsrrc_pkg::dsrrc_cmd_t cmd_o,
    output logic      [2:0]       bank_o,
    output logic      [15:0]      addr_o
);
    import dsrrc_pkg::*;
    localparam int TRP_CYC = 1;
    // Column gap; back-to-back drives are already two edges apart
    localparam int CCD_CYC = 4;
    // Read latency 5 plus column delay 4 plus 2, less write latency 5
    localparam int RD2WR = 6;
    logic [7:0] open_q;

    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = DSRRC_CMD_NOP;
        bank_o = 3'h0;
        addr_o = 16'h0;
        open_q = 8'h00;
    end

    task automatic drv(input dsrrc_cmd_t c, input logic [2:0] b, input logic [15:0] a);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o <= c;
        bank_o <= b;
        addr_o <= a;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_o <= DSRRC_CMD_NOP;
        // Inverse of last value, so a stale address is never read as valid
        addr_o <= ~a;
        if (c == DSRRC_CMD_ACT) open_q[b] = 1'b1;
        if (c == DSRRC_CMD_PRE && a[10]) open_q = 8'h00;
        if (c != DSRRC_CMD_ACT && (c == DSRRC_CMD_PRE || a[10])) open_q[b] = 1'b0;
    endtask : drv

    // Bad set: skip the housekeeping so a scenario can break the protocol
    task automatic issue(input dsrrc_cmd_t c, input logic [2:0] b, input logic [15:0] a,
                         input logic bad);
        if (!bad && c == DSRRC_CMD_ACT && open_q[b]) begin
            drv(DSRRC_CMD_PRE, b, 16'h0);
            repeat (TRP_CYC) @(posedge clk_i);
        end
        if (!bad && (c == DSRRC_CMD_RD || c == DSRRC_CMD_WR) && !open_q[b]) begin
            drv(DSRRC_CMD_ACT, b, 16'h0);
        end
        // Spaced as if a read just went out, so chopped four-beat bursts never overlap
        if (c == DSRRC_CMD_RD) repeat (CCD_CYC - 2) @(posedge clk_i);
        if (c == DSRRC_CMD_WR) repeat (RD2WR - 2) @(posedge clk_i);
        drv(c, b, a);
    endtask : issue
endmodule : dsrrc_ctl_model

// >>> dsrrc_top_asserts.sv
// Port checks for the row and read control block
`timescale 1ns/100ps
module dsrrc_top_chk (
    input wire logic                  CLK_I,
    input wire logic                  SRST_I,
    input wire logic                  CYC_I,
    input wire logic                  STB_I,
    input wire logic                  WE_I,
    input wire logic      [7:0]       ADR_I,
    input wire logic      [31:0]      DAT_O,
    input wire logic                  ACK_O,
    input wire logic                  CMD_VALID_I,
    input wire dsrrc_pkg::dsrrc_cmd_t CMD_I,
    input wire logic                  DLL_LOCKED_I,
    input wire logic                  RD_VALID_O,
    input wire logic                  CMD_ERR_O
);
    import dsrrc_pkg::*;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    wire rd_cmd = CMD_VALID_I && (CMD_I == DSRRC_CMD_RD);

    a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack held too long");
    a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not acked");
    a_dat_quiet: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("data without ack");
    a_err_sticky: assert property (
        CMD_ERR_O && !(CYC_I && STB_I && WE_I && ADR_I == 8'h0c) |=> CMD_ERR_O)
        else $error("error flag dropped");
    a_err_cause: assert property (
        $rose(CMD_ERR_O) |-> $past(CMD_VALID_I) && $past(CMD_I) != DSRRC_CMD_PRE)
        else $error("error without bad command");
    a_burst_min: assert property ($rose(RD_VALID_O) |-> RD_VALID_O[*4])
        else $error("burst shorter than four");
    // Latency of 5 holds while the latency register keeps its reset value
    a_read_latency: assert property ($rose(RD_VALID_O) |->
        $past(rd_cmd && DLL_LOCKED_I, 6))
        else $error("burst start off latency");
    a_unlocked_mute: assert property (rd_cmd && !DLL_LOCKED_I |-> ##6 !RD_VALID_O)
        else $error("data while loop unlocked");
endmodule : dsrrc_top_chk

bind dsrrc_top dsrrc_top_chk dsrrc_top_chk_i (.CLK_I(CLK_I), .SRST_I(SRST_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I), .DLL_LOCKED_I(DLL_LOCKED_I),
    .RD_VALID_O(RD_VALID_O), .CMD_ERR_O(CMD_ERR_O));

// >>> tb_top.sv
// Self-checking bench for the row and read control block
`timescale 1ns/100ps
`include "dsrrc_defines.svh"
module tb_top;
    import dsrrc_pkg::*;
    logic        clk, srst, cyc, stb, we, dll, ack, rd_vld, cmd_err, cmd_vld;
    logic [7:0]  adr, rd_dat;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, d;
    logic [2:0]  bank;
    logic [15:0] addr;
    dsrrc_cmd_t  cmd;
    logic [7:0]  exp_q [$];
    int          err_count = 0;
    int          cmp_count = 0;

    dsrrc_top dsrrc_top_i (.CLK_I(clk), .SRST_I(srst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
        .CMD_VALID_I(cmd_vld), .CMD_I(cmd), .BANK_I(bank), .ADDR_I(addr), .DLL_LOCKED_I(dll),
        .RD_VALID_O(rd_vld), .RD_DATA_O(rd_dat), .CMD_ERR_O(cmd_err));
    dsrrc_ctl_model dsrrc_ctl_model_i (.clk_i(clk), .cmd_valid_o(cmd_vld), .cmd_o(cmd),
        .bank_o(bank), .addr_o(addr));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        // Sampled at the edge, before that edge's updates land
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("ack cycles", 32'd2, n);
    endtask : wb

    task automatic rd(input logic [2:0] b, input logic [15:0] a, input logic bad);
        dsrrc_ctl_model_i.issue(DSRRC_CMD_RD, b, a, bad);
    endtask : rd

    task automatic see_burst(input int lat);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (rd_vld !== 1'b1 && n < 40);
        chk("latency", lat, n);
        foreach (exp_q[k]) begin
            if (k > 0) begin
                @(posedge clk);
                #1;
            end
            chk("valid", 1'b1, rd_vld);
            chk("beat", exp_q[k], rd_dat);
        end
        @(posedge clk);
        #1;
        chk("burst end", 1'b0, rd_vld);
        exp_q.delete();
    endtask : see_burst

    task automatic see_none;
        repeat (12) begin
            @(posedge clk);
            #1;
            chk("no data", 1'b0, rd_vld);
        end
    endtask : see_none

    task automatic arr(input logic [7:0] s, input int n);
        for (int k = 0; k < n; k++) exp_q.push_back(s + k[7:0]);
    endtask : arr

    task automatic calq(input logic [7:0] p, input int s, input int n);
        for (int k = 0; k < n; k++) exp_q.push_back({8{p[s+k]}});
    endtask : calq

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_regs;
        wb(1'b0, `DSRRC_OFF_MODE0, 32'h0);
        chk("mode0", 32'h0, d);
        wb(1'b0, `DSRRC_OFF_CAL, 32'h0);
        chk("pattern", 32'haa, d);
        wb(1'b0, `DSRRC_OFF_LAT, 32'h0);
        chk("latency reg", 32'h50, d);
        wb(1'b1, 8'h40, 32'hffff);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, d);
    endtask : t_regs

    task automatic t_row;
        dsrrc_ctl_model_i.issue(DSRRC_CMD_ACT, 3'h3, 16'hbeef, 1'b0);
        wb(1'b0, `DSRRC_OFF_ROWBASE + 8'h0c, 32'h0);
        chk("open row", 32'hbeef, d);
        wb(1'b0, `DSRRC_OFF_STATUS, 32'h0);
        chk("open banks", 8'h08, d[9:2]);
        arr(8'h10, 8);
        rd(3'h3, 16'h1010, 1'b0);
        see_burst(5);
        arr(8'h18, 8);
        rd(3'h3, 16'h0018, 1'b0);
        see_burst(5);
    endtask : t_row

    task automatic t_chop;
        wb(1'b1, `DSRRC_OFF_MODE0, 32'h1);
        arr(8'h20, 4);
        rd(3'h3, 16'h0020, 1'b0);
        see_burst(5);
        arr(8'h20, 8);
        rd(3'h3, 16'h1020, 1'b0);
        see_burst(5);
        arr(8'h28, 4);
        rd(3'h3, 16'h0428, 1'b0);
        see_burst(5);
        wb(1'b0, `DSRRC_OFF_STATUS, 32'h0);
        chk("closed by auto", 8'h00, d[9:2]);
    endtask : t_chop

    task automatic t_b2b;
        dsrrc_ctl_model_i.issue(DSRRC_CMD_ACT, 3'h0, 16'h0001, 1'b0);
        dsrrc_ctl_model_i.issue(DSRRC_CMD_ACT, 3'h1, 16'h0002, 1'b0);
        arr(8'h30, 4);
        arr(8'h40, 4);
        rd(3'h0, 16'h0430, 1'b0);
        rd(3'h1, 16'h0040, 1'b0);
        // Second read is the last call; the first burst starts one edge later
        see_burst(1);
        dsrrc_ctl_model_i.issue(DSRRC_CMD_WR, 3'h1, 16'h0400, 1'b0);
        wb(1'b0, `DSRRC_OFF_STATUS, 32'h0);
        chk("closed by write", 8'h00, d[9:2]);
        chk("write error", 1'b0, cmd_err);
    endtask : t_b2b

    task automatic t_pre;
        dsrrc_ctl_model_i.issue(DSRRC_CMD_ACT, 3'h5, 16'h0005, 1'b0);
        dsrrc_ctl_model_i.issue(DSRRC_CMD_PRE, 3'h1, 16'h0000, 1'b0);
        dsrrc_ctl_model_i.issue(DSRRC_CMD_PRE, 3'h1, 16'h0000, 1'b0);
        wb(1'b0, `DSRRC_OFF_STATUS, 32'h0);
        chk("one bank closed", 9'h041, d[9:1]);
        dsrrc_ctl_model_i.issue(DSRRC_CMD_PRE, 3'h0, 16'h0400, 1'b0);
        wb(1'b0, `DSRRC_OFF_STATUS, 32'h0);
        chk("all closed", 8'h00, d[9:2]);
        rd(3'h5, 16'h0000, 1'b1);
        see_none();
        chk("error flag", 1'b1, cmd_err);
        wb(1'b1, `DSRRC_OFF_STATUS, 32'h0);
        #1;
        chk("error cleared", 1'b0, cmd_err);
    endtask : t_pre

    task automatic t_cal;
        wb(1'b1, `DSRRC_OFF_MODE3, 32'h4);
        wb(1'b1, `DSRRC_OFF_MODE0, 32'h0);
        calq(8'haa, 0, 8);
        rd(3'h7, 16'h1000, 1'b1);
        see_burst(5);
        wb(1'b1, `DSRRC_OFF_CAL, 32'h1e);
        wb(1'b1, `DSRRC_OFF_MODE0, 32'h2);
        calq(8'h1e, 0, 4);
        rd(3'h7, 16'h0000, 1'b1);
        see_burst(5);
        wb(1'b1, `DSRRC_OFF_MODE0, 32'h1);
        calq(8'h1e, 4, 4);
        rd(3'h7, 16'h0004, 1'b1);
        see_burst(5);
        wb(1'b1, `DSRRC_OFF_MODE3, 32'h0);
    endtask : t_cal

    task automatic t_dll;
        dsrrc_ctl_model_i.issue(DSRRC_CMD_ACT, 3'h2, 16'h0007, 1'b0);
        dll <= 1'b0;
        rd(3'h2, 16'h1000, 1'b0);
        see_none();
        dll <= 1'b1;
    endtask : t_dll

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #250000;
        err_count++;
        wrap_up();
    end

    initial begin
        srst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0;
        dll = 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_row();
        t_chop();
        t_b2b();
        t_pre();
        t_cal();
        t_dll();
        wrap_up();
    end
endmodule : tb_top
